// File: bgp_bridge_gate_protection.sv
// Gate drive sequencing, short to ground and open load logic for three half bridges
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "bgp_consts.svh"
module bgp_bridge_gate_protection import bgp_pkg::*; #(
  parameter int NB = `BGP_NUM_BR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic hw_output_disable_n_i,
  input wire logic [NB-1:0] hs_cmd_i,
  input wire logic [NB-1:0] ls_cmd_i,
  input wire logic [NB-1:0] hs_gate_off_i,
  input wire logic [NB-1:0] ls_gate_off_i,
  input wire logic [NB-1:0] bridge_midpoint_voltage_i,
  input wire logic [NB-1:0] polarity_i,
  input wire logic [NB-1:0] chop_event_i,
  input wire logic [NB-1:0] target_missed_i,
  input wire logic [4:0] actual_current_i,
  output logic [NB-1:0] hs_gate_o,
  output logic [NB-1:0] ls_gate_o,
  output logic [NB-1:0] chop_abort_o,
  output logic [1:0] low_side_slope_sel_o,
  output logic [1:0] high_side_slope_sel_o,
  output logic driver_enabled_o
);
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Delays round down to whole cycles; each at least one cycle
  function automatic logic [`BGP_DLY_W-1:0] dly_cycles(input logic [1:0] code);
    int ns;
    int cyc;
    ns = `BGP_DLY_NS3;
    unique case (code)
      2'h0: ns = `BGP_DLY_NS0;
      2'h1: ns = `BGP_DLY_NS1;
      2'h2: ns = `BGP_DLY_NS2;
      2'h3: ns = `BGP_DLY_NS3;
    endcase
    cyc = (ns * (`BGP_CLK_HZ / 1000000)) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[`BGP_DLY_W-1:0];
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [`BGP_CTRL_W-1:0] ctrl;
  logic [`BGP_ST_W-1:0] irq_stat;
  logic [`BGP_ST_W-1:0] irq_en;
  logic [NB-1:0] ground_short_flag;
  logic [NB-1:0] open_load_flag;
  logic shutdown;
  logic [1:0] short_cnt [NB];
  logic bus_hit;
  logic bus_wr;
  logic [3:0] off_time_setting;
  logic [1:0] ground_short_delay_sel;
  logic fullstep_mode;
  logic drv_en;

  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_hit && wb_we_i && wb_sel_i[0];
  assign off_time_setting = ctrl[`BGP_F_OFF_TIME_SETTING_HI:`BGP_F_OFF_TIME_SETTING_LO];
  assign ground_short_delay_sel = ctrl[`BGP_F_DLY_HI:`BGP_F_DLY_LO];
  assign fullstep_mode = ctrl[`BGP_F_FULLSTEP];

  // One answer per request, registered a cycle after it; ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_hit;
    end
  end

  // Control word; low byte lane needs sel[0], upper bits sel[1]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `BGP_CTRL_RST;
    end else if (bus_hit && wb_we_i && wb_adr_i == `BGP_A_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[`BGP_CTRL_W-1:8] <= wb_dat_i[`BGP_CTRL_W-1:8];
      end
    end
  end

  // Interrupt enable word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= '0;
    end else if (bus_wr && wb_adr_i == `BGP_A_EN) begin
      irq_en <= wb_dat_i[`BGP_ST_W-1:0];
    end
  end

  // Read data from flops; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_hit && !wb_we_i) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        `BGP_A_CTRL: wb_dat_o[`BGP_CTRL_W-1:0] <= ctrl;
        `BGP_A_STAT: wb_dat_o <= {18'h00000, shutdown, drv_en,
                                  open_load_flag, ground_short_flag, irq_stat};
        `BGP_A_EN: wb_dat_o[`BGP_ST_W-1:0] <= irq_en;
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Enable and slope
  // ----------------------------------------
  // Both disables feed one term so they behave identically
  assign drv_en = !hw_output_disable_n_i && (off_time_setting != 4'h0);
  assign driver_enabled_o = drv_en && !shutdown;

  // Codes above the top setting clamp to it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_side_slope_sel_o <= 2'h0;
      high_side_slope_sel_o <= 2'h0;
    end else begin
      low_side_slope_sel_o <= (ctrl[`BGP_F_LSS_HI:`BGP_F_LSS_LO] > `BGP_LS_SLOPE_MAX) ?
        `BGP_LS_SLOPE_MAX : ctrl[`BGP_F_LSS_HI:`BGP_F_LSS_LO];
      high_side_slope_sel_o <= ctrl[`BGP_F_HSS_HI:`BGP_F_HSS_LO];
    end
  end

  // ----------------------------------------
  // Per bridge sequencing and short detect
  // ----------------------------------------
  logic [NB-1:0] short_det;
  logic [NB-1:0] pol_q;
  logic [NB-1:0] pol_chg;
  logic [NB-1:0] chop_seen;
  logic [NB-1:0] miss_seen;
  logic [NB-1:0] sc_hit;
  logic [NB-1:0] ol_hit;
  assign pol_chg = polarity_i ^ pol_q;

  for (genvar b = 0; b < NB; b++) begin : g_br
    bgp_gate_t st;
    logic [`BGP_DLY_W-1:0] tmr;
    assign hs_gate_o[b] = (st == BGP_HS_ON);
    // Low gate waits only for the high gate; gating on its own sense would make it oscillate
    assign ls_gate_o[b] = (st == BGP_OFF) && ls_cmd_i[b] && hs_gate_off_i[b]
                          && driver_enabled_o && !short_det[b] ? 1'b1 : 1'b0;

    // Gate state; high side waits for the low gate to discharge
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st <= BGP_OFF;
        tmr <= '0;
        short_det[b] <= 1'b0;
      end else begin
        short_det[b] <= 1'b0;
        unique case (st)
          BGP_OFF: begin
            if (driver_enabled_o && hs_cmd_i[b] && !ls_cmd_i[b]) begin
              st <= BGP_WAIT_LS;
            end
          end
          BGP_WAIT_LS: begin
            if (!driver_enabled_o || !hs_cmd_i[b]) begin
              st <= BGP_OFF;
            end else if (ls_gate_off_i[b]) begin
              st <= BGP_HS_ON;
              tmr <= dly_cycles(ground_short_delay_sel);
            end
          end
          BGP_HS_ON: begin
            if (!driver_enabled_o || !hs_cmd_i[b]) begin
              st <= BGP_WAIT_HS;
            end else if (!bridge_midpoint_voltage_i[b]) begin
              if (tmr == '0) begin
                st <= BGP_WAIT_HS;
                short_det[b] <= 1'b1;
              end else begin
                tmr <= tmr - 1'b1;
              end
            end
          end
          BGP_WAIT_HS: begin
            if (hs_gate_off_i[b]) begin
              st <= BGP_OFF;
            end
          end
        endcase
      end
    end

    // Short counter: saturates both ends, cleared by disable
    always_ff @(posedge clk_i) begin
      if (rst_i || !drv_en) begin
        short_cnt[b] <= 2'h0;
      end else if (short_det[b] && !pol_chg[b]) begin
        if (short_cnt[b] != `BGP_SHORT_LIMIT) begin
          short_cnt[b] <= short_cnt[b] + 2'h1;
        end
      end else if (pol_chg[b] && !short_det[b] && short_cnt[b] != 2'h0) begin
        short_cnt[b] <= short_cnt[b] - 2'h1;
      end
    end
    assign sc_hit[b] = short_det[b] && short_cnt[b] != 2'h0;
  end

  // Abort the chopper cycle on the coil whose bridge shorted
  assign chop_abort_o = short_det;

  // Latched shutdown; only a disable then enable releases it
  always_ff @(posedge clk_i) begin
    if (rst_i || !drv_en) begin
      shutdown <= 1'b0;
    end else begin
      for (int i = 0; i < NB; i++) begin
        if (short_cnt[i] == `BGP_SHORT_LIMIT) begin
          shutdown <= 1'b1;
        end
      end
    end
  end

  // Ground short flag: a repeat short within the count window means it persists
  always_ff @(posedge clk_i) begin
    if (rst_i || !drv_en) begin
      ground_short_flag <= '0;
    end else begin
      ground_short_flag <= ground_short_flag | sc_hit;
    end
  end

  // ----------------------------------------
  // Open load
  // ----------------------------------------
  // Evaluated at each polarity toggle; held at low current
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_q <= '0;
      chop_seen <= '0;
      miss_seen <= '0;
      open_load_flag <= '0;
    end else begin
      pol_q <= polarity_i;
      for (int i = 0; i < NB; i++) begin
        if (pol_chg[i]) begin
          if (actual_current_i >= `BGP_CUR_MIN) begin
            open_load_flag[i] <= !chop_seen[i] || (fullstep_mode && miss_seen[i]);
          end
          chop_seen[i] <= chop_event_i[i];
          miss_seen[i] <= target_missed_i[i];
        end else begin
          chop_seen[i] <= chop_seen[i] | chop_event_i[i];
          miss_seen[i] <= miss_seen[i] | target_missed_i[i];
        end
      end
    end
  end
  assign ol_hit = pol_chg & {NB{actual_current_i >= `BGP_CUR_MIN}}
                  & (~chop_seen | ({NB{fullstep_mode}} & miss_seen));

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Events: short detected, open load found; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((bus_wr && wb_adr_i == `BGP_A_CLR) ?
                   wb_dat_i[`BGP_ST_W-1:0] : '0)) | {ol_hit, short_det};
    end
  end
  assign irq_o = |(irq_stat & irq_en);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_hs_short(int k);
    hs_gate_o[k] && !bridge_midpoint_voltage_i[k];
  endsequence

  AST_NO_CROSS: assert property (@(posedge clk_i) disable iff (rst_i)
    (hs_gate_o & ls_gate_o) == '0) else $error("Both gates on in one bridge");
  AST_HW_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_output_disable_n_i |-> ls_gate_o == '0 && !driver_enabled_o ##1 hs_gate_o == '0)
    else $error("Outputs live while hardware disabled");
  AST_OFF_TIME_SETTING_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    off_time_setting == 4'h0 |-> !driver_enabled_o) else $error("Zero off time left driver on");
  AST_SHORT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    short_det[0] |-> !hs_gate_o[0] && chop_abort_o[0]) else $error("Shorted bridge not off");
  AST_SHORT_DLY: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(hs_gate_o[0]) ##0 s_hs_short(0) [*2] |-> !short_det[0])
    else $error("Short flagged too early");
  AST_SHUT_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    shutdown && drv_en |=> shutdown) else $error("Shutdown released while enabled");
  AST_S2G_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    !drv_en |=> ground_short_flag == '0) else $error("Ground short flag not cleared");
  AST_CNT_DIS: assert property (@(posedge clk_i) disable iff (rst_i)
    !drv_en |=> short_cnt[0] == 2'h0) else $error("Short counter not reset");
  AST_OL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    actual_current_i < `BGP_CUR_MIN |=> $stable(open_load_flag))
    else $error("Open load changed at low current");
  AST_LS_SLOPE: assert property (@(posedge clk_i) disable iff (rst_i)
    low_side_slope_sel_o <= `BGP_LS_SLOPE_MAX) else $error("Low side slope above top");

  // Gate order: each gate rises only once its counterpart reads discharged
  AST_HS_AFTER_LS: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(hs_gate_o[0]) |-> $past(ls_gate_off_i[0]))
    else $error("High gate on before low gate discharged");
  AST_LS_AFTER_HS: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ls_gate_o[0]) |-> hs_gate_off_i[0])
    else $error("Low gate on before high gate discharged");

  // A short needs the high gate on for at least the shortest detection delay
  AST_SHORT_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
    short_det[0] |-> $past(hs_gate_o[0], `BGP_DLY_MIN_CYC))
    else $error("Short flagged before the detection delay");

  // Counter steps: up per short, down per polarity change, floored at zero
  AST_CNT_UP: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_en && short_det[0] && !pol_chg[0] && short_cnt[0] != `BGP_SHORT_LIMIT
    |=> short_cnt[0] == $past(short_cnt[0]) + 2'h1)
    else $error("Short counter missed a short");
  AST_CNT_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_en && pol_chg[0] && !short_det[0]
    |=> short_cnt[0] == (($past(short_cnt[0]) == 2'h0) ? 2'h0 : $past(short_cnt[0]) - 2'h1))
    else $error("Short counter step down wrong");
  AST_SHUT_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_en && short_cnt[0] == `BGP_SHORT_LIMIT |=> shutdown && !driver_enabled_o)
    else $error("Shutdown missing at short limit");
  AST_S2G_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    drv_en && short_det[0] && short_cnt[0] != 2'h0 |=> ground_short_flag[0])
    else $error("Repeated short left ground flag clear");

  // Open load verdicts at a polarity toggle with enough current
  AST_OL_EVAL: assert property (@(posedge clk_i) disable iff (rst_i)
    pol_chg[1] && actual_current_i >= `BGP_CUR_MIN && !chop_seen[1] |=> open_load_flag[1])
    else $error("Open load not flagged after quiet interval");
  AST_OL_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    pol_chg[1] && actual_current_i >= `BGP_CUR_MIN && chop_seen[1] && !fullstep_mode
    |=> !open_load_flag[1]) else $error("Open load kept despite chopper event");
  AST_OL_MISS: assert property (@(posedge clk_i) disable iff (rst_i)
    pol_chg[1] && actual_current_i >= `BGP_CUR_MIN && fullstep_mode && miss_seen[1]
    |=> open_load_flag[1]) else $error("Missed target not flagged in fullstep");
endmodule

// File: bgp_consts.svh
// Constants for the bridge gate protection block
`ifndef BGP_CONSTS_SVH
`define BGP_CONSTS_SVH
`define BGP_CLK_HZ 20000000
`define BGP_NUM_BR 3
`define BGP_SHORT_LIMIT 2'h3
`define BGP_LS_SLOPE_MAX 2'h2
`define BGP_HS_SLOPE_MAX 2'h3
`define BGP_CUR_MIN 5'h02
`define BGP_DLY_NS0 2000
`define BGP_DLY_NS1 1500
`define BGP_DLY_NS2 1000
`define BGP_DLY_NS3 500
`define BGP_DLY_W 6
`define BGP_DLY_MIN_CYC 10
`define BGP_A_CTRL 4'h0
`define BGP_A_STAT 4'h4
`define BGP_A_CLR 4'h8
`define BGP_A_EN 4'hc
`define BGP_F_OFF_TIME_SETTING_LO 0
`define BGP_F_OFF_TIME_SETTING_HI 3
`define BGP_F_LSS_LO 4
`define BGP_F_LSS_HI 5
`define BGP_F_HSS_LO 6
`define BGP_F_HSS_HI 7
`define BGP_F_DLY_LO 8
`define BGP_F_DLY_HI 9
`define BGP_F_FULLSTEP 10
`define BGP_CTRL_W 11
`define BGP_CTRL_RST 11'h000
`define BGP_ST_W 6
`endif

// File: bgp_pkg.sv
// Types for the bridge gate protection block
package bgp_pkg;
  typedef enum logic [1:0] {
    BGP_OFF = 2'b00,
    BGP_WAIT_LS = 2'b01,
    BGP_HS_ON = 2'b10,
    BGP_WAIT_HS = 2'b11
  } bgp_gate_t;
endpackage

// File: bgp_bridge_model.sv
// Behavioural model of the three external MOSFET half bridges
`timescale 1ns/10ps
module bgp_bridge_model (
  input wire logic clk_i,
  input wire logic [2:0] hs_gate_i,
  input wire logic [2:0] ls_gate_i,
  input wire logic [2:0] short_i,
  output logic [2:0] hs_gate_off_o,
  output logic [2:0] ls_gate_off_o,
  output logic [2:0] bridge_midpoint_voltage_o
);
  logic [2:0] hs_q;
  logic [2:0] ls_q;
  // Gates take two cycles to discharge, so the overlap guard really has to wait
  always_ff @(posedge clk_i) begin
    hs_q <= hs_gate_i;
    ls_q <= ls_gate_i;
    hs_gate_off_o <= ~(hs_q | hs_gate_i);
    ls_gate_off_o <= ~(ls_q | ls_gate_i);
    bridge_midpoint_voltage_o <= hs_q & ~short_i; // A shorted output never rises
  end
endmodule

// File: bridge_gate_protection_logic_bench.sv
// Self-checking bench for the bridge gate protection block
`timescale 1ns/10ps
`include "bgp_consts.svh"
module bridge_gate_protection_logic_bench;
  typedef struct packed {logic [10:0] c; logic [1:0] l; logic [1:0] h; logic e;} bgp_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr, q;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack, irq, drv, dis_n = 1'b0;
  logic [2:0] hs_cmd = 3'h0, ls_cmd = 3'h0, pol = 3'h0, chop = 3'h0, miss = 3'h0, sh = 3'h0;
  logic [2:0] hs_off, ls_off, mid, hs_g, ls_g, abort;
  logic [1:0] lss, hss;
  logic [4:0] cur = 5'h10;
  int errors = 0;
  int n_tests = 0;
  int n;
  int dly[4] = '{`BGP_DLY_NS0 / 50, `BGP_DLY_NS1 / 50, `BGP_DLY_NS2 / 50, `BGP_DLY_NS3 / 50};
  // Slope rows, the last one with off time zero; low-side code 3 clamps to 2
  bgp_row_t rows[5] = '{'{11'h002, 2'h0, 2'h0, 1'b1}, '{11'h052, 2'h1, 2'h1, 1'b1},
    '{11'h0a2, 2'h2, 2'h2, 1'b1}, '{11'h0f2, 2'h2, 2'h3, 1'b1}, '{11'h0f0, 2'h2, 2'h3, 1'b0}};

  bgp_bridge_gate_protection bgp_bridge_gate_protection_i (
    .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .irq_o(irq), .hw_output_disable_n_i(dis_n), .hs_cmd_i(hs_cmd), .ls_cmd_i(ls_cmd),
    .hs_gate_off_i(hs_off), .ls_gate_off_i(ls_off), .bridge_midpoint_voltage_i(mid),
    .polarity_i(pol), .chop_event_i(chop), .target_missed_i(miss),
    .actual_current_i(cur), .hs_gate_o(hs_g), .ls_gate_o(ls_g), .chop_abort_o(abort),
    .low_side_slope_sel_o(lss), .high_side_slope_sel_o(hss), .driver_enabled_o(drv));
  bgp_bridge_model bgp_bridge_model_i (.clk_i(clk), .hs_gate_i(hs_g), .ls_gate_i(ls_g),
    .short_i(sh), .hs_gate_off_o(hs_off), .ls_gate_off_o(ls_off),
    .bridge_midpoint_voltage_o(mid));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // A hung wait is counted and ends the run
  task automatic lim(input int i);
    if (i >= 60) begin
      errors++;
      end_sim();
    end
  endtask
  // Classic cycle: request held until the edge that samples ack
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] r);
    int i;
    @(posedge clk);
    adr <= a;
    we <= w;
    dw <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 60);
    lim(i);
    r = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  // High-side request on bridge 0; time the abort from gate on
  task automatic short_once(input int c);
    @(posedge clk) hs_cmd <= 3'h1;
    n = 0;
    while (hs_g[0] !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    lim(n);
    check("ls off at hs on", ls_off[0], 1'b1);
    n = 0;
    while (abort[0] !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    lim(n);
    check("short delay", n >= dly[c] - 2 && n <= dly[c] + 3, 1'b1);
    @(posedge clk);
    check("hs off on short", hs_g[0], 1'b0);
    hs_cmd <= 3'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic tgl();
    @(posedge clk) pol[0] <= ~pol[0];
    repeat (3) @(posedge clk);
  endtask
  // Chopper and missed-target pulses on bridge 1, then a polarity change
  task automatic ol(input logic [2:0] c, input logic [2:0] m, output logic [31:0] s);
    @(posedge clk) chop <= c;
    miss <= m;
    @(posedge clk);
    chop <= 3'h0;
    miss <= 3'h0;
    @(posedge clk) pol[1] <= ~pol[1];
    repeat (3) @(posedge clk);
    wb(`BGP_A_STAT, 1'b0, 32'h0, s);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("idle outputs", {ack, irq, hs_g, ls_g, drv}, 9'h0);
    wb(4'h1, 1'b0, 32'h0, q);
    check("unmapped", q, 32'h0);
    foreach (rows[i]) begin
      wb(`BGP_A_CTRL, 1'b1, 32'(rows[i].c), q);
      wb(`BGP_A_CTRL, 1'b0, 32'h0, q);
      check("ctrl", q, 32'(rows[i].c));
      check("low slope", lss, rows[i].l);
      check("high slope", hss, rows[i].h);
      check("enable", drv, rows[i].e);
    end
    wb(`BGP_A_CTRL, 1'b1, 32'h002, q);
    ls_cmd <= 3'h1;
    n = 0;
    while (ls_g[0] !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    lim(n);
    check("hs off at ls on", hs_off[0], 1'b1);
    dis_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("pin disable", {drv, ls_g}, 4'h0);
    dis_n <= 1'b0;
    ls_cmd <= 3'h0;
    ol(3'h0, 3'h0, q);
    check("open set", q[10], 1'b1);
    ol(3'h2, 3'h0, q);
    check("open clear", q[10], 1'b0);
    cur <= 5'h01;
    ol(3'h0, 3'h0, q);
    check("open held", q[10], 1'b0);
    cur <= 5'h10;
    wb(`BGP_A_CTRL, 1'b1, 32'h402, q);
    ol(3'h2, 3'h2, q);
    check("open missed", q[10], 1'b1);
    sh <= 3'h1;
    for (int c = 0; c < 4; c++) begin
      wb(`BGP_A_CTRL, 1'b1, 32'h002 | (c << 8), q);
      short_once(c);
      tgl();
    end
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("short irq masked", {q[0], irq}, 2'h2);
    wb(`BGP_A_EN, 1'b1, 32'h1, q);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("irq on", irq, 1'b1);
    wb(`BGP_A_CLR, 1'b1, 32'h1, q);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("irq cleared", {irq, q[0]}, 2'h0);
    short_once(3);
    short_once(3);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("ground flag", q[6], 1'b1);
    short_once(3);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("shutdown", {q[13], drv}, 2'h2);
    wb(`BGP_A_CTRL, 1'b1, 32'h000, q);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("disable clears", {q[13], q[6]}, 2'h0);
    wb(`BGP_A_CTRL, 1'b1, 32'h302, q);
    short_once(3);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("count reset", {q[13], drv}, 2'h1);
    tgl();
    tgl();
    repeat (2) short_once(3);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("floor at zero", q[13], 1'b0);
    short_once(3);
    wb(`BGP_A_STAT, 1'b0, 32'h0, q);
    check("third short", {q[13], drv}, 2'h2);
    end_sim();
  end
endmodule
